/* rtl/advanced_timer_pkg.sv */
// Package of the advanced timer time base: register offsets, field layouts,
// reset values and the packed carriers shared by the design.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package advanced_timer_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_AUTO_RELOAD = 8'h04;
    localparam logic [7:0] OFS_REPEAT_COUNT = 8'h08;
    localparam logic [7:0] OFS_MAIN_COUNTER = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFS_COMPARE = 8'h18;

    // ------------------------------------------------------------------
    // Field widths and positions
    // ------------------------------------------------------------------
    localparam int PSC_W = 8;
    localparam int REP_W = 8;
    localparam int CTRL_W = 19;
    localparam int REP_REG_W = 10;
    localparam int SW_UPDATE_BIT = 19;
    localparam int FLAG_TOP_BIT = 0;
    localparam int FLAG_BOTTOM_BIT = 1;
    localparam int FLAG_UPDATE_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] AUTO_RELOAD_RST = 16'hFFFF;
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam logic [31:0] IRQ_CLEAR_READ = 32'h0000_0007;

    // Timer control register, top bit downward.
    typedef struct packed {
        logic [PSC_W-1:0] prescaleSetting;
        logic compareBufferEnable;
        logic triggerFallingEdge;
        logic bottomWrapIrqEnable;
        logic topWrapIrqEnable;
        logic updateIrqEnable;
        logic tickSourceChoice;
        logic updateSourceSelect;
        logic reloadBufferEnable;
        logic centerMode;
        logic countHeading;
        logic timerEnable;
    } timer_ctrl_s;

    localparam timer_ctrl_s CTRL_RST = '0;

    // Repeat count register, top bit downward.
    typedef struct packed {
        logic bottomRepeatInhibit;
        logic topRepeatInhibit;
        logic [REP_W-1:0] repeatCountValue;
    } repeat_cfg_s;

    localparam repeat_cfg_s REPEAT_RST = '0;

endpackage : advanced_timer_pkg

/* rtl/advanced_timer.sv */
// Time base of the advanced timer: prescaler, main counter, repetition
// counter, update events and wrap flags behind an AHB-Lite slave.
// Assumes one AHB-Lite master on mclk; the external trigger is asynchronous,
// the slave-mode reset comes from logic on mclk.
`timescale 1ns/1ps

module advanced_timer
    import advanced_timer_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic externalTriggerInput,
    input wire logic slaveModeReset,
    output logic updateEvent,
    output logic topReachedPulse,
    output logic bottomReachedPulse,
    output logic irqRequest,
    output logic [CNT_W-1:0] mainCounter,
    output logic countingDown,
    output logic [CNT_W-1:0] compareActive
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
            $error("CNT_W must lie between 2 and 16");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // Zero wait states: reads are sampled in the address phase, so a read
    // right behind a write to the same register returns the older value.
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] rdWord;
    timer_ctrl_s ctrl_q;
    timer_ctrl_s ctrl_d;
    repeat_cfg_s repCfg_q;
    logic swUpdateReq_q;
    logic [CNT_W-1:0] arrPend_q;
    logic [CNT_W-1:0] arrAct_q;
    logic [CNT_W-1:0] arrAct_d;
    logic [CNT_W-1:0] ccrPend_q;
    logic [CNT_W-1:0] ccrAct_q;
    logic [CNT_W-1:0] ccrAct_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [REP_W-1:0] repCnt_q;
    logic [REP_W-1:0] repCnt_d;
    logic [PSC_W-1:0] presc_q;
    logic [PSC_W-1:0] presc_d;
    logic topFlag_q;
    logic bottomFlag_q;
    logic updFlag_q;

    wire addrPhase = hsel & hready & htrans[1];
    wire [7:0] rdAddr = haddr[7:0];
    wire [CNT_W-1:0] wrVal = hwdata[CNT_W-1:0];
    wire wrCtrl = wrPend_q & (wrAddr_q == OFS_TIMER_CONTROL);
    wire wrArr = wrPend_q & (wrAddr_q == OFS_AUTO_RELOAD);
    wire wrRep = wrPend_q & (wrAddr_q == OFS_REPEAT_COUNT);
    wire wrClr = wrPend_q & (wrAddr_q == OFS_IRQ_CLEAR);
    wire wrCcr = wrPend_q & (wrAddr_q == OFS_COMPARE);

    always_comb begin
        case (rdAddr)
            OFS_TIMER_CONTROL: rdWord = 32'({swUpdateReq_q, ctrl_q});
            OFS_AUTO_RELOAD: rdWord = 32'(arrPend_q);
            OFS_REPEAT_COUNT: rdWord = 32'(repCfg_q);
            OFS_MAIN_COUNTER: rdWord = 32'(cnt_q);
            OFS_IRQ_STATUS: rdWord = 32'({updFlag_q, bottomFlag_q, topFlag_q});
            OFS_IRQ_CLEAR: rdWord = IRQ_CLEAR_READ;
            OFS_COMPARE: rdWord = 32'(ccrPend_q);
            default: rdWord = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            wrAddr_q <= rdAddr;
            hrdata <= (addrPhase & ~hwrite) ? rdWord : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    logic trigMeta_q;
    logic trigSync_q;
    logic trigPrev_q;
    logic enPrev_q;

    wire running = ctrl_q.timerEnable;
    wire startNow = running & ~enPrev_q;
    wire trigRise = trigSync_q & ~trigPrev_q;
    wire trigFall = ~trigSync_q & trigPrev_q;
    wire trigTick = ctrl_q.triggerFallingEdge ? trigFall : trigRise;
    wire prescHit = presc_q == ctrl_q.prescaleSetting;
    wire tick = running & (ctrl_q.tickSourceChoice ? trigTick : prescHit);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trigMeta_q <= 1'b0;
            trigSync_q <= 1'b0;
            trigPrev_q <= 1'b0;
            enPrev_q <= 1'b0;
        end else begin
            trigMeta_q <= externalTriggerInput;
            trigSync_q <= trigMeta_q;
            trigPrev_q <= trigSync_q;
            enPrev_q <= running;
        end
    end

    // ------------------------------------------------------------------
    // Wrap and update detection
    // ------------------------------------------------------------------
    wire goingUp = ~ctrl_q.countHeading;
    wire center = ctrl_q.centerMode;
    wire atTop = cnt_q == arrAct_q;
    wire atBottom = cnt_q == '0;
    wire topWrap = tick & goingUp & atTop;
    wire bottomWrap = tick & ~goingUp & atBottom;
    wire wrap = topWrap | bottomWrap;
    wire repInUse = repCfg_q.repeatCountValue != '0;
    wire inhibit = topWrap ? repCfg_q.topRepeatInhibit
                           : repCfg_q.bottomRepeatInhibit;
    wire repCounts = wrap & ~inhibit;
    // The update falls on the counted wrap that finds the repetition counter
    // at one and reloads it, so a repeat count of N gives one update every N wraps.
    // A counter already at zero, for instance after the repeat count was
    // written while running, still updates on its next counted wrap.
    // An inhibited wrap neither counts nor updates while repeats are in use.
    wire repLast = repCnt_q <= REP_W'(1);
    wire counterUev = wrap & (repInUse ? (repCounts & repLast)
                                       : 1'b1);
    wire forcedReq = swUpdateReq_q | slaveModeReset;
    wire forcedUev = forcedReq & ~ctrl_q.updateSourceSelect;
    wire uevNow = counterUev | forcedUev;
    wire arrXfer = uevNow & ctrl_q.reloadBufferEnable;
    wire [CNT_W-1:0] arrNew = arrXfer ? arrPend_q : arrAct_q;

    // ------------------------------------------------------------------
    // Prescaler and repetition counter
    // ------------------------------------------------------------------
    // The prescaler restarts on every update and on start, so the first
    // tick after either comes a full division period later.
    // The setting itself is never touched by hardware.
    always_comb begin
        if (!running || uevNow || startNow || prescHit) begin
            presc_d = '0;
        end else begin
            presc_d = presc_q + 1'b1;
        end
    end

    always_comb begin
        repCnt_d = repCnt_q;
        if (startNow || uevNow) begin
            repCnt_d = repCfg_q.repeatCountValue;
        end else if (repCounts && repCnt_q != '0) begin
            repCnt_d = repCnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------------
    // A limitation: in edge up mode a count already above the reload value
    // runs on to the top of the counter before it wraps to zero.
    // Software should issue an update first when it shrinks the reload
    // value of a stopped timer.
    // A software update while stopped still resets the count outside center mode, which gives
    // software a clean way to park the counter.
    always_comb begin
        cnt_d = cnt_q;
        if (startNow && !center && ctrl_q.countHeading) begin
            cnt_d = arrNew;
        end else if (forcedUev && !center) begin
            cnt_d = goingUp ? '0 : arrNew;
        end else if (topWrap) begin
            cnt_d = !center ? '0 : (atBottom ? cnt_q : cnt_q - 1'b1);
        end else if (bottomWrap) begin
            cnt_d = !center ? arrNew : (atTop ? cnt_q : cnt_q + 1'b1);
        end else if (tick) begin
            cnt_d = goingUp ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control register and counting direction
    // ------------------------------------------------------------------
    // The heading bit has two writers, software and the center mode logic.
    // Software wins outside center mode; a write that enters center mode
    // clears the bit to count up, and in center mode the hardware direction is
    // kept on a control write, so only a software update that the write requests reverses a running sweep.
    timer_ctrl_s ctrlWr;
    logic hwHeading;

    assign ctrlWr = timer_ctrl_s'(hwdata[CTRL_W-1:0]);

    always_comb begin
        hwHeading = ctrl_q.countHeading;
        if (center && topWrap) begin
            hwHeading = 1'b1;
        end else if (center && bottomWrap) begin
            hwHeading = 1'b0;
        end else if (center && forcedUev) begin
            hwHeading = ~ctrl_q.countHeading;
        end
        ctrl_d = ctrl_q;
        ctrl_d.countHeading = hwHeading;
        if (wrCtrl) begin
            ctrl_d = ctrlWr;
            if (ctrlWr.centerMode && !center) begin
                ctrl_d.countHeading = 1'b0;
            end else if (ctrlWr.centerMode) begin
                ctrl_d.countHeading = hwHeading;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reload and compare shadows
    // ------------------------------------------------------------------
    // A bus write outranks a simultaneous update transfer, so the value just
    // written is never overwritten by an older pending one.
    wire arrDirect = ~running | ~ctrl_q.reloadBufferEnable;
    wire ccrDirect = ~running | ~ctrl_q.compareBufferEnable;
    assign arrAct_d = (wrArr & arrDirect) ? wrVal
                    : arrXfer ? arrPend_q : arrAct_q;
    assign ccrAct_d = (wrCcr & ccrDirect) ? wrVal
                    : (uevNow & ctrl_q.compareBufferEnable) ? ccrPend_q
                    : ccrAct_q;

    // ------------------------------------------------------------------
    // Flags, with a set winning over a clear in the same cycle
    // ------------------------------------------------------------------
    wire clrTop = wrClr & ~hwdata[FLAG_TOP_BIT];
    wire clrBottom = wrClr & ~hwdata[FLAG_BOTTOM_BIT];
    wire clrUpd = wrClr & ~hwdata[FLAG_UPDATE_BIT];
    wire topFlag_d = topWrap | (topFlag_q & ~clrTop);
    wire bottomFlag_d = bottomWrap | (bottomFlag_q & ~clrBottom);
    wire updFlag_d = uevNow | (updFlag_q & ~clrUpd);
    // The request follows the next flag and enable values, so it drops in
    // the same cycle as a clear or a disable becomes visible.
    wire irq_d = (updFlag_d & ctrl_d.updateIrqEnable)
               | (topFlag_d & ctrl_d.topWrapIrqEnable)
               | (bottomFlag_d & ctrl_d.bottomWrapIrqEnable);

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            repCfg_q <= REPEAT_RST;
            swUpdateReq_q <= 1'b0;
            arrPend_q <= AUTO_RELOAD_RST[CNT_W-1:0];
            arrAct_q <= AUTO_RELOAD_RST[CNT_W-1:0];
            ccrPend_q <= COMPARE_RST[CNT_W-1:0];
            ccrAct_q <= COMPARE_RST[CNT_W-1:0];
        end else begin
            ctrl_q <= ctrl_d;
            repCfg_q <= wrRep ? repeat_cfg_s'(hwdata[REP_REG_W-1:0]) : repCfg_q;
            swUpdateReq_q <= wrCtrl & hwdata[SW_UPDATE_BIT];
            arrPend_q <= wrArr ? wrVal : arrPend_q;
            arrAct_q <= arrAct_d;
            ccrPend_q <= wrCcr ? wrVal : ccrPend_q;
            ccrAct_q <= ccrAct_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            repCnt_q <= '0;
            presc_q <= '0;
            topFlag_q <= 1'b0;
            bottomFlag_q <= 1'b0;
            updFlag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            repCnt_q <= repCnt_d;
            presc_q <= presc_d;
            topFlag_q <= topFlag_d;
            bottomFlag_q <= bottomFlag_d;
            updFlag_q <= updFlag_d;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            updateEvent <= 1'b0;
            topReachedPulse <= 1'b0;
            bottomReachedPulse <= 1'b0;
            irqRequest <= 1'b0;
            mainCounter <= '0;
            countingDown <= 1'b0;
            compareActive <= COMPARE_RST[CNT_W-1:0];
        end else begin
            updateEvent <= uevNow;
            topReachedPulse <= topWrap;
            bottomReachedPulse <= bottomWrap;
            irqRequest <= irq_d;
            mainCounter <= cnt_d;
            countingDown <= ctrl_d.countHeading;
            compareActive <= ccrAct_d;
        end
    end

endmodule : advanced_timer

/* sim/advanced_timer_assertions.sv */
// Checker of the advanced timer time base, bound to its top module.
// Assumes one clock, mclk, and the active-low asynchronous reset rst_n.
`timescale 1ns/1ps

module advanced_timer_assertions
    import advanced_timer_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic externalTriggerInput,
    input wire logic slaveModeReset,
    input wire logic updateEvent,
    input wire logic topReachedPulse,
    input wire logic bottomReachedPulse,
    input wire logic irqRequest,
    input wire logic [CNT_W-1:0] mainCounter,
    input wire logic countingDown,
    input wire logic [CNT_W-1:0] compareActive
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Read data may only stand in the cycle after a read address phase.
    logic rdPh_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rdPh_q <= 1'b0;
        else rdPh_q <= hsel && hready && htrans[1] && !hwrite;
    end

    chk_update_single: assert property (
        updateEvent |=> !updateEvent)
        else $error("update pulse longer than one cycle");
    chk_top_single: assert property (
        topReachedPulse |=> !topReachedPulse)
        else $error("top pulse longer than one cycle");
    chk_bottom_single: assert property (
        bottomReachedPulse |=> !bottomReachedPulse)
        else $error("bottom pulse longer than one cycle");
    chk_wrap_exclusive: assert property (
        !(topReachedPulse && bottomReachedPulse))
        else $error("top and bottom pulses together");
    chk_up_step: assert property ((!countingDown && !$past(countingDown)
        && mainCounter != $past(mainCounter)) |-> (mainCounter == '0
        || mainCounter == $past(mainCounter) + 1'b1))
        else $error("up counter jumped");
    chk_ready_high: assert property ($past(rst_n) |-> hreadyout)
        else $error("slave inserted a wait state");
    chk_resp_okay: assert property (!hresp)
        else $error("slave gave an error response");
    chk_rdata_idle: assert property (!rdPh_q |-> hrdata == '0)
        else $error("read data outside a read data phase");
endmodule : advanced_timer_assertions

bind advanced_timer advanced_timer_assertions #(.CNT_W(CNT_W)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .externalTriggerInput(externalTriggerInput),
    .slaveModeReset(slaveModeReset), .updateEvent(updateEvent),
    .topReachedPulse(topReachedPulse),
    .bottomReachedPulse(bottomReachedPulse), .irqRequest(irqRequest),
    .mainCounter(mainCounter), .countingDown(countingDown),
    .compareActive(compareActive));

/* sim/tb.sv */
// Self-checking bench of the advanced timer time base.
// Assumes the bench is the only AHB-Lite master and drives all pins.
`timescale 1ns/1ps

module tb;
    import advanced_timer_pkg::*;
    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic mclk, rst_n, hsel, hwrite, extTrig, slaveRst, rdPh;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic hreadyout, hresp, updateEvent, topReachedPulse;
    logic bottomReachedPulse, irqRequest, countingDown;
    logic [15:0] mainCounter, compareActive;
    logic [16:0] rnd;
    logic [31:0] expQ[$];
    string nameQ[$];
    int errors, checks, psc, n;
    wire hready = hreadyout;

    advanced_timer DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .externalTriggerInput(extTrig), .slaveModeReset(slaveRst),
        .updateEvent(updateEvent), .topReachedPulse(topReachedPulse),
        .bottomReachedPulse(bottomReachedPulse), .irqRequest(irqRequest),
        .mainCounter(mainCounter), .countingDown(countingDown),
        .compareActive(compareActive));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr

    function automatic logic pick(input int s);
        return s == 0 ? updateEvent : (s == 1 ? topReachedPulse
            : bottomReachedPulse);
    endfunction : pick

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // Address phase is held until hready is seen high at an edge.
    task automatic addr(input logic [7:0] a, input logic w);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (!hready) @(posedge mclk);
        htrans <= 2'h0;
    endtask : addr

    task automatic ahbW(input logic [7:0] a, input logic [31:0] d);
        addr(a, 1'b1);
        hwdata <= d;
        @(posedge mclk);
        while (!hready) @(posedge mclk);
    endtask : ahbW

    task automatic ahbR(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        addr(a, 1'b0);
        expQ.push_back(e);
        nameQ.push_back(nm);
        @(posedge mclk);
        while (!hready) @(posedge mclk);
    endtask : ahbR

    // Cycles from one pulse of the chosen kind to the next.
    task automatic gap(input int s, input int e, input string nm);
        int c;
        c = 0;
        @(posedge mclk);
        while (!pick(s)) @(posedge mclk);
        do begin
            @(posedge mclk);
            c++;
        end while (!pick(s));
        chk(nm, c, e);
    endtask : gap

    task automatic cnt(input int s, input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge mclk);
            if (pick(s)) c++;
        end
    endtask : cnt

    task automatic pulseSlave;
        @(posedge mclk);
        slaveRst <= 1'b1;
        @(posedge mclk);
        slaveRst <= 1'b0;
        cnt(0, 6, n);
    endtask : pulseSlave

    // Read data is compared at the edge that ends its data phase.
    always @(posedge mclk) begin
        string nm;
        logic [31:0] e;
        if (rdPh) begin
            nm = nameQ.pop_front();
            e = expQ.pop_front();
            chk(nm, hrdata, e);
        end
        rdPh <= hsel && hready && htrans[1] && !hwrite;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {rst_n, hsel, hwrite, extTrig, slaveRst} = '0;
        haddr = '0;
        hwdata = '0;
        htrans = '0;
        rnd = 17'h12216;
        errors = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        ahbW(8'h0C, 32'h0000_0012);
        ahbR(8'h00, 32'h0, "ctrl rst");
        ahbR(8'h04, 32'h0000_FFFF, "reload rst");
        ahbR(8'h08, 32'h0, "repeat rst");
        ahbR(8'h0C, 32'h0, "counter ro");
        ahbR(8'h10, 32'h0, "status rst");
        ahbR(8'h14, 32'h7, "clear read");
        ahbR(8'h18, 32'h0, "compare rst");
        ahbR(8'h1C, 32'h0, "unmapped");
        $display("test reset done");
        rnd = lfsr(rnd);
        psc = int'(rnd[1:0]);
        ahbW(8'h04, 32'h5);
        ahbW(8'h00, 32'h0000_00C1 | (32'(psc) << 11));
        gap(1, 6 * (psc + 1), "up period");
        gap(0, 6 * (psc + 1), "up update");
        chk("up irq", irqRequest, 32'h1);
        ahbW(8'h00, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq masked", irqRequest, 32'h0);
        ahbR(8'h10, 32'h5, "up flags");
        ahbW(8'h14, 32'h0);
        ahbR(8'h10, 32'h0, "flags cleared");
        $display("test up done");
        ahbW(8'h00, 32'h0000_0103 | (32'(psc) << 11));
        gap(2, 6 * (psc + 1), "down period");
        chk("down dir", countingDown, 32'h1);
        chk("down irq", irqRequest, 32'h1);
        ahbW(8'h00, 32'h0);
        ahbW(8'h14, 32'h0);
        ahbW(8'h00, 32'h6);
        repeat (2) @(posedge mclk);
        chk("center dir", countingDown, 32'h0);
        ahbR(8'h00, 32'h4, "heading ignored");
        ahbW(8'h00, 32'h7 | (32'(psc) << 11));
        gap(1, 10 * (psc + 1), "center top");
        gap(0, 5 * (psc + 1), "center update");
        $display("test down and center done");
        ahbW(8'h00, 32'h8_0000);
        ahbW(8'h04, 32'h3);
        ahbW(8'h08, 32'h2);
        ahbW(8'h00, 32'h1);
        gap(0, 8, "repeat period");
        ahbW(8'h00, 32'h0);
        ahbW(8'h08, 32'h102);
        ahbW(8'h00, 32'h1);
        cnt(0, 40, n);
        chk("top inhibit", n, 32'h0);
        ahbW(8'h00, 32'h0);
        ahbW(8'h08, 32'h202);
        ahbW(8'h00, 32'h3);
        cnt(0, 40, n);
        chk("bottom inhibit", n, 32'h0);
        ahbW(8'h00, 32'h0);
        ahbW(8'h08, 32'h0);
        $display("test repeat done");
        ahbW(8'h04, 32'h20);
        ahbW(8'h00, 32'h409);
        ahbW(8'h18, 32'h55);
        ahbW(8'h04, 32'h3);
        ahbR(8'h04, 32'h3, "pending reload");
        chk("compare held", {16'h0000, compareActive}, 32'h0);
        ahbW(8'h00, 32'h8_0409);
        gap(0, 4, "buffered period");
        chk("compare moved", {16'h0000, compareActive}, 32'h55);
        ahbR(8'h00, 32'h409, "sw self clear");
        ahbW(8'h00, 32'h0);
        pulseSlave();
        chk("slave update", n, 32'h1);
        ahbW(8'h00, 32'h10);
        pulseSlave();
        chk("slave masked", n, 32'h0);
        ahbW(8'h00, 32'h8_0010);
        cnt(0, 6, n);
        chk("sw masked", n, 32'h0);
        $display("test update done");
        ahbW(8'h00, 32'h8_0000);
        ahbR(8'h0C, 32'h0, "counter reset");
        ahbW(8'h00, 32'h21);
        repeat (2) begin
            @(posedge mclk);
            extTrig <= 1'b1;
            repeat (4) @(posedge mclk);
            extTrig <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        ahbR(8'h0C, 32'h2, "trigger count");
        $display("test trigger done");
        finish_test();
    end
endmodule : tb
